//--- bsrc_defines.svh
// Purpose: Shared constants of the backup store/recall controller
// Assumes: Included by bare name from the package, the controller and the bench
// Notes:   Times are in ns; cycle counts derive from the clock period
`ifndef BSRC_DEFINES_SVH
`define BSRC_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and transfer times
// ----------------------------------------------------------------
`define BSRC_CLK_PERIOD_NS   5
`define BSRC_STORE_TIME_NS   8000000
`define BSRC_RESTORE_TIME_NS 1000000

// ----------------------------------------------------------------
// Configuration word: {page_rollover_select, block_protect_bits, auto_backup_disable_n}
// ----------------------------------------------------------------
`define BSRC_CFG_W           4
`define BSRC_CFG_AUTO_DIS_BIT 0
`define BSRC_CFG_FACTORY     4'h0
`define BSRC_USER_W          16

// ----------------------------------------------------------------
// Status byte and opcodes (opcode values are arbitrary defaults)
// ----------------------------------------------------------------
`define BSRC_STAT_BUSY_BIT   0
`define BSRC_OP_READ_STATUS  8'h05
`define BSRC_OP_STORE        8'hA1
`define BSRC_OP_RECALL       8'hA2
`define BSRC_OP_HIBERNATE    8'hA3

`endif

//--- bsrc_pkg.sv
// Purpose: Types of the backup store/recall controller
// Assumes: bsrc_defines.svh supplies the widths
// Notes:   Controller state is one packed struct
`include "bsrc_defines.svh"

package bsrc_pkg;

   // Gray coded along idle -> store -> recall -> hibernate
   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_STORE  = 2'h1,
      ST_RECALL = 2'h3,
      ST_HIBER  = 2'h2
   } bsrc_state_type;

   typedef enum logic [1:0] {
      K_AUTO = 2'h0,
      K_SW   = 2'h1,
      K_HIB  = 2'h3
   } bsrc_kind_type;

   typedef struct packed {
      bsrc_state_type           state;
      bsrc_kind_type            kind;
      logic [31:0]              timer;
      logic                     modified;
      logic                     powered;
      logic                     cap_q;
      logic                     sck_q;
      logic                     cs_q;
      logic                     vcc_conn;
      logic [2:0]               bit_cnt;
      logic [7:0]               shift;
      logic [7:0]               opcode;
      logic                     first_done;
      logic                     status_rd;
      logic                     cmd_ok;
      logic [7:0]               tx;
      logic                     miso;
      logic                     store_start;
      logic                     recall_start;
      logic                     restore_load;
      logic [`BSRC_CFG_W-1:0]   bkp_cfg;
      logic [`BSRC_USER_W-1:0]  bkp_user;
      logic [`BSRC_CFG_W-1:0]   cfg_out;
      logic [`BSRC_USER_W-1:0]  user_out;
   } bsrc_regs_type;

endpackage

//--- bsrc_sync.sv
// Purpose: Two-flop synchroniser for pins from outside the clock domain
// Assumes: Inputs are levels; one bit per lane
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps

module bsrc_sync #(
   parameter int W = 1
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_reset,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   // Stage one in the low half, stage two in the high half
   logic [2*W-1:0] r;
   logic [2*W-1:0] next_r;

   if (W < 1) begin : g_chk
      $error("bsrc_sync: W must be at least 1");
   end

   // Shift one stage per clock
   always_comb begin
      next_r = {r[W-1:0], i_d};
   end

   // Register the chain
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_q = r[2*W-1:W];

endmodule

//--- bsrc_ctrl.sv
// Purpose: Store/recall sequencing between the SRAM array and its backup
// Assumes: Serial pins and supply comparators are asynchronous levels
// Notes:   Array, user word and status paths live outside this block
`timescale 1ns/1ps
`include "bsrc_defines.svh"

// Contract
// - Factory auto_backup_disable_n bit is zero
// - Auto backup only if enabled and modified
// - Refuse access for whole store duration
// - Supply return mid-backup: finish, skip restore
// - Power-up restore always, busy for duration
// - Power loss aborts restore, no backup
// - Store command copies array, word, config
// - Recall command reloads array, word, config
// - While busy only read_status_cmd is accepted
// - transfer_busy_flag is one during transfers
// - read_status_cmd streams fresh status bytes
// - Hibernate: wait deselect, store if modified
// - Wake on select or power cycle, restore
// - Rising over trip_threshold starts restore
// - Below trip_threshold: ignore, drive nothing; a select in hibernate still starts a restore
// - Reconnect main supply only after stores
module bsrc_ctrl #(
   parameter int         STORE_TIME_NS   = `BSRC_STORE_TIME_NS,
   parameter int         RESTORE_TIME_NS = `BSRC_RESTORE_TIME_NS,
   parameter logic [7:0] OP_READ_STATUS  = `BSRC_OP_READ_STATUS,
   parameter logic [7:0] OP_STORE        = `BSRC_OP_STORE,
   parameter logic [7:0] OP_RECALL       = `BSRC_OP_RECALL,
   parameter logic [7:0] OP_HIBERNATE    = `BSRC_OP_HIBERNATE
) (
   input  wire logic                     i_sys_clk,
   input  wire logic                     i_reset,
   input  wire logic                     i_sck,
   input  wire logic                     i_cs_n,
   input  wire logic                     i_mosi,
   input  wire logic                     i_cap_above_trip,
   input  wire logic                     i_vcc_above_cap,
   input  wire logic                     i_array_write_done,
   input  wire logic [`BSRC_CFG_W-1:0]   i_cfg,
   input  wire logic [`BSRC_USER_W-1:0]  i_user_word,
   input  wire logic [7:0]               i_status_bits,
   output logic                          o_miso,
   output logic                          o_miso_oe,
   output logic                          o_busy,
   output logic                          o_cmd_allow,
   output logic                          o_hibernate,
   output logic                          o_vcc_connect,
   output logic                          o_store_start,
   output logic                          o_recall_start,
   output logic                          o_restore_load,
   output logic [`BSRC_CFG_W-1:0]        o_cfg_restore,
   output logic [`BSRC_USER_W-1:0]       o_user_restore,
   output bsrc_pkg::bsrc_state_type      o_state
);

   import bsrc_pkg::*;

   // ----------------------------------------------------------------
   // Durations in cycles (least times, rounded up)
   // ----------------------------------------------------------------
   localparam int STORE_CYC =
      (STORE_TIME_NS + `BSRC_CLK_PERIOD_NS - 1) / `BSRC_CLK_PERIOD_NS;
   localparam int RESTORE_CYC =
      (RESTORE_TIME_NS + `BSRC_CLK_PERIOD_NS - 1) / `BSRC_CLK_PERIOD_NS;

   if (STORE_CYC < 2 || RESTORE_CYC < 2) begin : g_chk
      $error("bsrc_ctrl: transfer times must span at least two cycles");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [4:0] sync_q;
   logic       sck_s;
   logic       cs_n_s;
   logic       mosi_s;
   logic       cap_s;
   logic       vcc_s;

   // Lanes reset low, so cs_n shows one rise after reset; no command is armed then
   bsrc_sync #(.W(5)) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_d       ({i_sck, i_cs_n, i_mosi, i_cap_above_trip, i_vcc_above_cap}),
      .o_q       (sync_q)
   );

   assign {sck_s, cs_n_s, mosi_s, cap_s, vcc_s} = sync_q;

   // ----------------------------------------------------------------
   // Edges and derived conditions
   // ----------------------------------------------------------------
   bsrc_regs_type r;
   bsrc_regs_type n;
   logic          cap_rise;
   logic          cap_fall;
   logic          sck_rise;
   logic          sck_fall;
   logic          cs_rise;
   logic          cs_fall;
   logic          busy;
   logic [7:0]    status_byte;
   logic [7:0]    rx_byte;

   assign cap_rise = cap_s && !r.cap_q;
   assign cap_fall = !cap_s && r.cap_q;
   assign sck_rise = sck_s && !r.sck_q;
   assign sck_fall = !sck_s && r.sck_q;
   assign cs_rise  = cs_n_s && !r.cs_q;
   assign cs_fall  = !cs_n_s && r.cs_q;
   assign busy     = (r.state == ST_STORE) || (r.state == ST_RECALL);
   assign rx_byte  = {r.shift[6:0], mosi_s};

   // Live status with the busy flag overlaid
   always_comb begin
      status_byte = i_status_bits;
      status_byte[`BSRC_STAT_BUSY_BIT] = busy;
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   logic          do_store;
   logic          do_recall;
   bsrc_kind_type store_kind;

   always_comb begin
      n = r;
      do_store = 1'b0;
      do_recall = 1'b0;
      store_kind = K_AUTO;
      n.store_start = 1'b0;
      n.recall_start = 1'b0;
      n.restore_load = 1'b0;
      n.cap_q = cap_s;
      n.sck_q = sck_s;
      n.cs_q = cs_n_s;

      // Supply tracking and main supply switchover
      if (cap_rise) begin
         n.powered = 1'b1;
      end
      if (cap_fall) begin
         n.powered = 1'b0;
         n.vcc_conn = 1'b0;
      end else if (!r.vcc_conn && vcc_s && r.state != ST_STORE) begin
         n.vcc_conn = 1'b1;
      end

      // Transfer timer counts down to one, then rests at zero
      if (r.timer != 32'h0) begin
         n.timer = r.timer - 32'h1;
      end

      // Transfer sequencing
      case (r.state)
         ST_IDLE: begin
            if (cap_rise) begin
               do_recall = 1'b1;
            end else if (cap_fall) begin
               if (!i_cfg[`BSRC_CFG_AUTO_DIS_BIT] && r.modified) begin
                  do_store = 1'b1;
                  store_kind = K_AUTO;
               end
            end else if (cs_rise && r.cmd_ok) begin
               if (r.opcode == OP_STORE) begin
                  do_store = 1'b1;
                  store_kind = K_SW;
               end else if (r.opcode == OP_RECALL) begin
                  do_recall = 1'b1;
               end else if (r.opcode == OP_HIBERNATE) begin
                  if (r.modified) begin
                     do_store = 1'b1;
                     store_kind = K_HIB;
                  end else begin
                     n.state = ST_HIBER;
                  end
               end
            end
         end
         ST_STORE: begin
            // Runs to the end whatever the supply does
            if (r.timer == 32'h1) begin
               n.modified = 1'b0;
               n.state = (r.kind == K_HIB) ? ST_HIBER : ST_IDLE;
            end
         end
         ST_RECALL: begin
            if (cap_fall) begin
               n.state = ST_IDLE;
               n.timer = 32'h0;
            end else if (r.timer == 32'h1) begin
               n.state = ST_IDLE;
               n.modified = 1'b0;
               n.restore_load = 1'b1;
               n.cfg_out = r.bkp_cfg;
               n.user_out = r.bkp_user;
            end
         end
         ST_HIBER: begin
            if (cap_rise || cs_fall) begin
               do_recall = 1'b1;
            end
         end
         default: begin
            n.state = ST_IDLE;
         end
      endcase

      // Launch a backup: capture word and configuration
      if (do_store) begin
         n.state = ST_STORE;
         n.kind = store_kind;
         n.timer = 32'(STORE_CYC);
         n.store_start = 1'b1;
         n.bkp_cfg = i_cfg;
         n.bkp_user = i_user_word;
      end
      if (do_recall) begin
         n.state = ST_RECALL;
         n.timer = 32'(RESTORE_CYC);
         n.recall_start = 1'b1;
      end

      // Array writes mark modified; a write beats the clear
      if (i_array_write_done) begin
         n.modified = 1'b1;
      end

      // Serial frame: deselect or low supply clears it
      if (cs_n_s || !r.powered) begin
         n.bit_cnt = 3'h0;
         n.first_done = 1'b0;
         n.status_rd = 1'b0;
         n.miso = 1'b0;
         // Drop the taken command so a later bare select cannot replay it
         n.cmd_ok = 1'b0;
      end else begin
         if (sck_rise) begin
            n.shift = rx_byte;
            n.bit_cnt = r.bit_cnt + 3'h1;
            if (r.bit_cnt == 3'h7) begin
               if (!r.first_done) begin
                  n.first_done = 1'b1;
                  n.opcode = rx_byte;
                  n.status_rd = (rx_byte == OP_READ_STATUS);
                  n.cmd_ok = (r.state == ST_IDLE) && (rx_byte != OP_READ_STATUS);
                  n.tx = status_byte;
               end else if (r.status_rd) begin
                  n.tx = status_byte;
               end
            end
         end
         if (sck_fall && r.status_rd) begin
            n.miso = r.tx[7];
            n.tx = {r.tx[6:0], 1'b0};
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         r <= '0;
         r.vcc_conn <= 1'b1;
         r.cs_q <= 1'b1;
         r.bkp_cfg <= `BSRC_CFG_FACTORY;
         r.cfg_out <= `BSRC_CFG_FACTORY;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_miso         = r.miso;
   assign o_miso_oe      = !r.cs_q && r.status_rd && r.powered;
   assign o_busy         = busy;
   assign o_cmd_allow    = r.powered && (r.state == ST_IDLE);
   assign o_hibernate    = (r.state == ST_HIBER);
   assign o_vcc_connect  = r.vcc_conn;
   assign o_store_start  = r.store_start;
   assign o_recall_start = r.recall_start;
   assign o_restore_load = r.restore_load;
   assign o_cfg_restore  = r.cfg_out;
   assign o_user_restore = r.user_out;
   assign o_state        = r.state;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   // Each property guards one rule; all rest while reset is high

   store_hold_a: assert property (o_store_start |-> (o_busy && !o_cmd_allow) [*8])
      else $error("store did not hold busy");
   auto_gate_a: assert property (
      (cap_fall && r.state == ST_IDLE)
      |=> (o_store_start == $past(r.modified && !i_cfg[`BSRC_CFG_AUTO_DIS_BIT])))
      else $error("auto backup gate wrong");
   skip_restore_a: assert property (
      (r.state == ST_STORE && r.kind == K_AUTO && cap_rise && r.timer > 32'h2)
      |=> ##1 (r.state == ST_STORE && !o_recall_start))
      else $error("restore started during backup");
   power_restore_a: assert property (
      (cap_rise && r.state == ST_IDLE) |=> o_recall_start ##1 o_busy [*4])
      else $error("no restore on power-up");
   abort_recall_a: assert property (
      (r.state == ST_RECALL && cap_fall) |=> (r.state == ST_IDLE && !o_store_start))
      else $error("restore not aborted");
   busy_status_a: assert property (
      (sck_rise && r.bit_cnt == 3'h7 && r.status_rd && !cs_n_s && r.powered)
      |=> r.tx[`BSRC_STAT_BUSY_BIT] == $past(o_busy))
      else $error("status busy bit stale");
   no_drive_a: assert property (!r.powered |-> !o_miso_oe ##1 !o_miso_oe)
      else $error("drive while unpowered");
   vcc_hold_a: assert property (
      (!o_vcc_connect && r.state == ST_STORE) |=> !o_vcc_connect)
      else $error("main supply reconnected mid-store");
   mod_set_a: assert property (i_array_write_done |=> r.modified)
      else $error("modified flag not set");
   busy_cmd_a: assert property ((busy && sck_rise && r.bit_cnt == 3'h7
      && !r.first_done && !cs_n_s) |=> !r.cmd_ok)
      else $error("command taken while busy");
   hib_wake_a: assert property (
      ((cap_rise || cs_fall) && r.state == ST_HIBER) |=> o_recall_start)
      else $error("no restore on wake");

   auto_backup_c: cover property (o_store_start && r.kind == K_AUTO);
   status_poll_c: cover property (r.status_rd && o_busy ##1 r.status_rd && !o_busy);
   hib_wake_c: cover property (o_hibernate ##1 o_recall_start);
   hib_store_c: cover property (o_store_start && r.kind == K_HIB);
   recall_abort_c: cover property (r.state == ST_RECALL && cap_fall);

endmodule

//--- bsrc_spi_master.sv
// Purpose: Serial master model that sends commands and polls status
// Assumes: Mode 0 link, 125 ns clock period, clock held low between frames
// Notes:   Data out is inverted after each frame so stale bits are not reused
`timescale 1ns/1ps

module bsrc_spi_master (
   input  wire logic i_miso,
   output logic      o_sck,
   output logic      o_cs_n,
   output logic      o_mosi
);
   localparam realtime HALF = 62.5;

   // Idle levels
   initial begin
      o_sck  = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end

   // One byte each way, MSB first, sample on rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_mosi = tx[i];
         #HALF o_sck = 1'b1;
         rx[i] = i_miso;
         #HALF o_sck = 1'b0;
      end
   endtask

   // Opcode, then status bytes until ready or max_rd bytes read
   task automatic frame(input logic [7:0] op, input int max_rd,
                        output logic [7:0] st, output int n_rd);
      logic [7:0] rx;
      st = 8'hFF;
      n_rd = 0;
      o_cs_n = 1'b0;
      #HALF xfer(op, rx);
      while (n_rd < max_rd && st[0] !== 1'b0) begin
         xfer(~op, st);
         n_rd++;
      end
      #HALF o_cs_n = 1'b1;
      o_mosi = ~o_mosi;
      #HALF;
   endtask

   // Bare select pulse that wakes a sleeping device
   task automatic wake();
      o_cs_n = 1'b0;
      #(4*HALF) o_cs_n = 1'b1;
      #HALF;
   endtask
endmodule

//--- bsrc_tb.sv
// Purpose: Self-checking bench of the store/recall controller
// Assumes: Short transfer times; opcodes from the shared header
// Notes:   Pulse counters watch the start and load strobes
`timescale 1ns/1ps
`include "bsrc_defines.svh"

module tb;
   import bsrc_pkg::*;
   localparam int SNS = 4000;
   localparam int RNS = 2000;
   localparam int SCYC = SNS / `BSRC_CLK_PERIOD_NS;
   localparam int RCYC = RNS / `BSRC_CLK_PERIOD_NS;

   logic clk, reset, sck, cs_n, mosi, cap, vcc, wr, miso, oe, flip, miso_line;
   logic busy, allow, hib, vconn, s_start, r_start, load;
   logic [3:0]  cfg, cfg_r, c;
   logic [15:0] user, user_r, u;
   logic [7:0]  stat, st;
   bsrc_state_type state;
   int n_errors = 0, compares = 0, n_store = 0, n_recall = 0, n_load = 0;
   int n_oe = 0, run = 0, len = 0, n, ns, nr, nl, no;

   // ------------------------------------------------------------
   // Device, master model and undriven line
   // ------------------------------------------------------------
   bsrc_ctrl #(.STORE_TIME_NS(SNS), .RESTORE_TIME_NS(RNS)) dut (
      .i_sys_clk(clk), .i_reset(reset), .i_sck(sck), .i_cs_n(cs_n), .i_mosi(mosi),
      .i_cap_above_trip(cap), .i_vcc_above_cap(vcc), .i_array_write_done(wr),
      .i_cfg(cfg), .i_user_word(user), .i_status_bits(stat), .o_miso(miso),
      .o_miso_oe(oe), .o_busy(busy), .o_cmd_allow(allow), .o_hibernate(hib),
      .o_vcc_connect(vconn), .o_store_start(s_start), .o_recall_start(r_start),
      .o_restore_load(load), .o_cfg_restore(cfg_r), .o_user_restore(user_r),
      .o_state(state));
   bsrc_spi_master m (.i_miso(miso_line), .o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi));
   assign miso_line = oe ? miso : flip; // Released line toggles

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Strobe counters and busy run length
   always @(posedge clk) begin
      flip <= ~flip;
      n_store  <= n_store + (s_start === 1'b1);
      n_recall <= n_recall + (r_start === 1'b1);
      n_load   <= n_load + (load === 1'b1);
      n_oe     <= n_oe + (oe === 1'b1);
      if (busy === 1'b1) begin
         run <= run + 1;
      end else if (run != 0) begin
         len <= run;
         run <= 0;
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %0h, seen %0h", name, e, g);
      end
   endtask

   task automatic end_sim();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic clks(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic wait_state(input bsrc_state_type s);
      int k;
      k = 0;
      while (state !== s && k < 5000) begin
         @(posedge clk);
         k++;
      end
      #1;
      if (k == 5000) begin
         chk("state_wait", s, state);
         end_sim();
      end
   endtask

   task automatic pulse_wr();
      wr = 1'b1;
      clks(1);
      wr = 1'b0;
      clks(2);
   endtask

   // One status poll frame with its checks
   task automatic poll();
      m.frame(`BSRC_OP_READ_STATUS, 40, st, n);
      chk("status", {stat[7:1], 1'b0}, st);
      chk("busy_seen", 1, n >= 2);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      reset = 1'b1;
      cap = 1'b1;
      vcc = 1'b1;
      wr = 1'b0;
      cfg = 4'h0;
      user = 16'h0;
      flip = 1'b0;
      void'($urandom(63));
      stat = 8'($urandom());
      clks(5);
      reset = 1'b0;
      clks(8);
      poll();
      chk("recall_cnt", 1, n_recall);
      chk("load_cnt", 1, n_load);
      chk("factory_cfg", 4'h0, cfg_r);
      chk("restore_len", RCYC, len);
      chk("allow", 1, allow);
      // Store then recall round trips with random contents
      for (int k = 0; k < 3; k++) begin
         c = 4'($urandom());
         u = 16'($urandom());
         cfg = c;
         user = u;
         pulse_wr();
         ns = n_store;
         nr = n_recall;
         m.frame(`BSRC_OP_STORE, 0, st, n);
         chk("busy", 1, busy);
         chk("allow_busy", 0, allow);
         if (k == 0) begin
            m.frame(`BSRC_OP_RECALL, 0, st, n);
         end
         poll();
         chk("store_cnt", ns + 1, n_store);
         chk("store_len", SCYC, len);
         chk("refused", nr, n_recall);
         cfg = ~c;
         user = ~u;
         nl = n_load;
         m.frame(`BSRC_OP_RECALL, 0, st, n);
         poll();
         chk("load_cnt", nl + 1, n_load);
         chk("cfg_back", c, cfg_r);
         chk("user_back", u, user_r);
         chk("recall_len", RCYC, len);
      end
      // Power loss with backup enabled, supply returns mid-store
      cfg = 4'h0;
      pulse_wr();
      ns = n_store;
      nr = n_recall;
      cap = 1'b0;
      vcc = 1'b0;
      clks(6);
      chk("auto_store", ns + 1, n_store);
      chk("vconn_off", 0, vconn);
      clks(100);
      cap = 1'b1;
      wait_state(ST_IDLE);
      clks(5);
      chk("no_restore", nr, n_recall);
      chk("auto_len", SCYC, len);
      chk("vconn_held", 0, vconn);
      vcc = 1'b1;
      clks(5);
      chk("vconn_on", 1, vconn);
      // Backup disabled, then silence below trip
      cfg = 4'h1;
      pulse_wr();
      ns = n_store;
      cap = 1'b0;
      clks(6);
      chk("disabled", ns, n_store);
      no = n_oe;
      m.frame(`BSRC_OP_READ_STATUS, 1, st, n);
      chk("silent", no, n_oe);
      // Restore aborted by power loss
      cfg = 4'h0;
      nr = n_recall;
      nl = n_load;
      cap = 1'b1;
      clks(6);
      chk("restore", nr + 1, n_recall);
      clks(50);
      cap = 1'b0;
      clks(6);
      chk("abort_state", ST_IDLE, state);
      clks(RCYC);
      chk("abort_load", nl, n_load);
      chk("abort_store", ns, n_store);
      cap = 1'b1;
      clks(6);
      wait_state(ST_IDLE);
      chk("reload", nl + 1, n_load);
      cap = 1'b0;
      clks(6);
      chk("unmodified", ns, n_store);
      cap = 1'b1;
      clks(6);
      wait_state(ST_IDLE);
      // Hibernate with modified array, then wake by select
      pulse_wr();
      ns = n_store;
      nr = n_recall;
      nl = n_load;
      m.frame(`BSRC_OP_HIBERNATE, 0, st, n);
      clks(2);
      chk("hib_store", ns + 1, n_store);
      wait_state(ST_HIBER);
      chk("hib", 1, hib);
      m.wake();
      clks(6);
      chk("wake", nr + 1, n_recall);
      wait_state(ST_IDLE);
      chk("awake", 0, hib);
      chk("wake_load", nl + 1, n_load);
      // Bare select when idle must not replay the last command
      m.wake();
      clks(6);
      chk("stale_cmd", 0, hib);
      chk("stale_store", ns + 1, n_store);
      end_sim();
   end
endmodule
